// *** src/smc_defines.vh ***
// Notes on behaviour
// - Supply runs in normal, stop and restart; off in sleep and fail-safe.
// - Fixed-frequency mode: constant switching rate, duty set by the closed loop.
// - Fixed-frequency mode lets the step-down duty reach 100% at low input.
// - Entering stop mode forces pulse-frequency modulation, which runs asynchronously, unless soft-start runs or the wake pin selects fixed frequency.
// - Soft-start runs at power-up and on sleep or fail-safe to restart.
// - Soft-start begins open loop at minimum duty, held for some switching periods.
// - Duty then rises in fixed steps, each held, until target voltage.
// - At target voltage the loop closes and fixed-frequency regulation continues.
// - Open or short fault bits only report; no mode or configuration change.
// - Enabled step-up turns on below threshold, off above threshold plus hysteresis.
// - Step-up active flag is set whenever the step-up has switched on.
// - Voltage select changes only while disabled; else write dropped, error flag set.
// - By default the step-down stays in pulse-frequency mode throughout stop.
// - Automatic and wake-pin bits both set: automatic transition wins.
// - Automatic and wake-pin bits both clear: pulse-frequency throughout stop.
// - I/O overvoltage with its fail enable bit set activates the fail output.
// - Automatic mode: load over threshold gives fixed-frequency, event and change flag.
// - Wake-pin mode: low gives pulse-frequency, high fixed-frequency, no delay.
`ifndef SMC_DEFINES_VH
`define SMC_DEFINES_VH

`define SMC_CLK_PERIOD_NS   25
`define SMC_TLAG_SHORT_NS   100000
`define SMC_TLAG_LONG_NS    1000000
`define SMC_SW_PERIOD_NS    2222
`define SMC_TLAG_SHORT_CYC  (`SMC_TLAG_SHORT_NS / `SMC_CLK_PERIOD_NS)
`define SMC_TLAG_LONG_CYC   (`SMC_TLAG_LONG_NS / `SMC_CLK_PERIOD_NS)
`define SMC_SW_PERIOD_CYC   (`SMC_SW_PERIOD_NS / `SMC_CLK_PERIOD_NS)

`define SMC_MODE_NORMAL     3'h1
`define SMC_MODE_STOP       3'h2
`define SMC_MODE_RESTART    3'h3
`define SMC_MODE_SLEEP      3'h4
`define SMC_MODE_FAILSAFE   3'h5

`define SMC_ADDR_CTRL       4'h0
`define SMC_ADDR_STATUS     4'h4
`define SMC_ADDR_FAULT      4'h8

`define SMC_CTRL_RESET      8'h00
`define SMC_CTRL_UP_EN      0
`define SMC_CTRL_VSEL_LO    1
`define SMC_CTRL_VSEL_HI    2
`define SMC_CTRL_AUTO       3
`define SMC_CTRL_WAKE_SEL   4
`define SMC_CTRL_TLAG_LONG  5
`define SMC_CTRL_OV_FAIL    6

`define SMC_ST_UP_FLAG      0
`define SMC_ST_MOD_FLAG     1
`define SMC_ST_CMD_ERR      2
`define SMC_ST_UP_ON        3
`define SMC_ST_PWM          4
`define SMC_ST_SS_BUSY      5
`define SMC_ST_CLOSED       6

`define SMC_FLT_OPEN        0
`define SMC_FLT_SHORT       1

`define SMC_SS_MIN_DUTY     8'h08
`define SMC_SS_STEP         8'h04
`define SMC_SS_HOLD_PER     4

`endif

// *** src/smc_sync.v ***
`timescale 1ns/1ps
module smc_sync #(
	parameter WIDTH = 1
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] din,
	output wire [WIDTH-1:0] dout
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg s1_q;
			reg s2_q;
			reg s3_q;
			reg out_q;
			// The value is taken only once the two late stages agree.
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					s1_q  <= 1'b0;
					s2_q  <= 1'b0;
					s3_q  <= 1'b0;
					out_q <= 1'b0;
				end else begin
					s1_q <= din[i];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q) begin
						out_q <= s3_q;
					end
				end
			end
			assign dout[i] = out_q;
		end
	endgenerate
endmodule // smc_sync

// *** src/smc_softstart.v ***
`timescale 1ns/1ps
`include "smc_defines.vh"
module smc_softstart #(
	parameter PERIOD_CYC = `SMC_SW_PERIOD_CYC,
	parameter HOLD_PER   = `SMC_SS_HOLD_PER
) (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       start,
	input  wire       abort,
	input  wire       target_hit,
	output reg  [7:0] duty_q,
	output reg        busy_q,
	output reg        closed_q
);
	localparam ST_IDLE = 4'h1;
	localparam ST_HOLD = 4'h2;
	localparam ST_RAMP = 4'h4;
	localparam ST_DONE = 4'h8;

	reg [3:0]  state_q;
	reg [3:0]  state_d;
	reg [15:0] cyc_q;
	reg [7:0]  per_q;
	wire       per_end;
	wire       hold_end;

	assign per_end  = (cyc_q == PERIOD_CYC[15:0] - 16'h0001);
	assign hold_end = per_end && (per_q == HOLD_PER[7:0] - 8'h01);

	always @* begin
		state_d = state_q;
		case (state_q)
		ST_IDLE: begin
			if (start) begin
				state_d = ST_HOLD;
			end
		end
		ST_HOLD: begin
			if (hold_end) begin
				state_d = ST_RAMP;
			end
		end
		ST_RAMP: begin
			if (target_hit) begin
				state_d = ST_DONE;
			end
		end
		ST_DONE: begin
			if (start) begin
				state_d = ST_HOLD;
			end
		end
		default: begin
			state_d = ST_IDLE;
		end
		endcase
		if (abort) begin
			state_d = ST_IDLE;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q  <= ST_IDLE;
			cyc_q    <= 16'h0000;
			per_q    <= 8'h00;
			duty_q   <= 8'h00;
			busy_q   <= 1'b0;
			closed_q <= 1'b0;
		end else begin
			state_q  <= state_d;
			busy_q   <= (state_d == ST_HOLD) || (state_d == ST_RAMP);
			closed_q <= (state_d == ST_DONE);
			if (state_d != state_q) begin
				cyc_q <= 16'h0000;
				per_q <= 8'h00;
			end else if (per_end) begin
				cyc_q <= 16'h0000;
				per_q <= hold_end ? 8'h00 : per_q + 8'h01;
			end else begin
				cyc_q <= cyc_q + 16'h0001;
			end
			if (state_d == ST_HOLD && state_q != ST_HOLD) begin
				duty_q <= `SMC_SS_MIN_DUTY;
			end else if (hold_end && !target_hit &&
				(state_q == ST_HOLD || state_q == ST_RAMP)) begin
				// Saturate rather than wrap so a slow rail never drops duty.
				if (duty_q > 8'hFF - `SMC_SS_STEP) begin
					duty_q <= 8'hFF;
				end else begin
					duty_q <= duty_q + `SMC_SS_STEP;
				end
			end else if (state_d == ST_IDLE) begin
				duty_q <= 8'h00;
			end
		end
	end
endmodule // smc_softstart

// *** src/smc_top.v ***
`timescale 1ns/1ps
`include "smc_defines.vh"
module smc_top #(
	parameter TLAG_SHORT_CYC = `SMC_TLAG_SHORT_CYC,
	parameter TLAG_LONG_CYC  = `SMC_TLAG_LONG_CYC,
	parameter SW_PERIOD_CYC  = `SMC_SW_PERIOD_CYC,
	parameter SS_HOLD_PER    = `SMC_SS_HOLD_PER
) (
	input  wire       REF_CLK,
	input  wire       RESETN,
	input  wire [2:0] CHIP_MODE,
	input  wire       STOP_CMD,
	input  wire [3:0] ADDR,
	input  wire [7:0] WDATA,
	input  wire       WR,
	input  wire       RD,
	output reg  [7:0] RDATA,
	input  wire       SUPPLY_BELOW_TH,
	input  wire       SUPPLY_ABOVE_HYST,
	input  wire       LOAD_OVER_TH,
	input  wire       WAKE_INPUT,
	input  wire       IO_SUPPLY_SENSE_OV,
	input  wire       OUT_TARGET_HIT,
	input  wire       FAULT_OPEN,
	input  wire       FAULT_SHORT,
	output reg        STEP_DOWN_EN,
	output reg        STEP_DOWN_PWM,
	output reg        STEP_DOWN_CLOSED_LOOP,
	output reg        STEP_DOWN_FULL_DUTY_OK,
	output reg  [7:0] STEP_DOWN_DUTY,
	output reg        STEP_UP_ON,
	output reg  [1:0] STEP_UP_VSEL,
	output reg        FAIL_OUTPUT,
	output reg        MOD_CHANGE_EVENT
);
	localparam MS_OFF  = 4'h1;
	localparam MS_RUN  = 4'h2;
	localparam MS_LAG  = 4'h4;
	localparam MS_STOP = 4'h8;

	wire [7:0] pin_raw;
	wire [7:0] pin_s;
	wire       below_s;
	wire       above_s;
	wire       load_s;
	wire       wake_s;
	wire       ov_s;
	wire       hit_s;
	wire       fopen_s;
	wire       fshort_s;

	reg  [7:0] ctrl_q;
	reg        up_flag_q;
	reg        mod_flag_q;
	reg        cmd_err_q;
	reg  [2:0] mode_prev_q;
	reg        power_up_q;
	reg  [3:0] ms_q;
	reg  [3:0] ms_d;
	reg  [16:0] lag_q;
	reg        auto_pwm_q;
	reg        up_on_q;

	reg        supply_run;
	reg        in_stop;
	wire       from_off;
	wire       wr_ctrl;
	wire       wr_status;
	wire       vsel_clash;
	wire [1:0] vsel_new;
	wire [1:0] vsel_cur;
	wire       ss_start;
	wire       lag_done;
	wire       auto_hit;
	reg        pwm_d;
	wire       ss_busy;
	wire       ss_closed;
	wire [7:0] ss_duty;
	wire [16:0] lag_len;
	wire [7:0] status_word;
	wire [7:0] fault_word;

	assign pin_raw = {FAULT_SHORT, FAULT_OPEN, OUT_TARGET_HIT,
		IO_SUPPLY_SENSE_OV, WAKE_INPUT, LOAD_OVER_TH,
		SUPPLY_ABOVE_HYST, SUPPLY_BELOW_TH};

	// Every sense and fault pin is asynchronous to this clock.
	smc_sync #(
		.WIDTH (8)
	) u_sync (
		.clk   (REF_CLK),
		.rst_n (RESETN),
		.din   (pin_raw),
		.dout  (pin_s)
	);

	assign below_s  = pin_s[0];
	assign above_s  = pin_s[1];
	assign load_s   = pin_s[2];
	assign wake_s   = pin_s[3];
	assign ov_s     = pin_s[4];
	assign hit_s    = pin_s[5];
	assign fopen_s  = pin_s[6];
	assign fshort_s = pin_s[7];

	// Chip mode is decoded directly on this clock.
	// Unused codes keep both stages off rather than guess at a mode.
	always @* begin
		supply_run = 1'b0;
		in_stop    = 1'b0;
		case (CHIP_MODE)
		`SMC_MODE_NORMAL: begin
			supply_run = 1'b1;
		end
		`SMC_MODE_STOP: begin
			supply_run = 1'b1;
			in_stop    = 1'b1;
		end
		`SMC_MODE_RESTART: begin
			supply_run = 1'b1;
		end
		default: begin
			supply_run = 1'b0;
		end
		endcase
	end

	assign from_off = (mode_prev_q == `SMC_MODE_SLEEP) ||
		(mode_prev_q == `SMC_MODE_FAILSAFE);

	// Soft-start from power-up or from a wake into restart.
	assign ss_start = supply_run && (power_up_q ||
		((CHIP_MODE == `SMC_MODE_RESTART) && from_off));

	smc_softstart #(
		.PERIOD_CYC (SW_PERIOD_CYC),
		.HOLD_PER   (SS_HOLD_PER)
	) u_ss (
		.clk        (REF_CLK),
		.rst_n      (RESETN),
		.start      (ss_start),
		.abort      (!supply_run),
		.target_hit (hit_s),
		.duty_q     (ss_duty),
		.busy_q     (ss_busy),
		.closed_q   (ss_closed)
	);

	assign wr_ctrl    = WR && (ADDR == `SMC_ADDR_CTRL);
	assign wr_status  = WR && (ADDR == `SMC_ADDR_STATUS);
	assign vsel_new   = WDATA[`SMC_CTRL_VSEL_HI:`SMC_CTRL_VSEL_LO];
	assign vsel_cur   = ctrl_q[`SMC_CTRL_VSEL_HI:`SMC_CTRL_VSEL_LO];
	// Comparing against the stored select lets software rewrite the same
	// value with the stage on, so a full-register update is not refused.
	assign vsel_clash = ctrl_q[`SMC_CTRL_UP_EN] &&
		(vsel_new != vsel_cur);

	// Software configuration register; a dropped write leaves it whole.
	always @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			ctrl_q <= `SMC_CTRL_RESET;
		end else if (wr_ctrl && !vsel_clash) begin
			ctrl_q <= {1'b0, WDATA[6:0]};
		end
	end

	assign lag_len = ctrl_q[`SMC_CTRL_TLAG_LONG] ?
		TLAG_LONG_CYC[16:0] : TLAG_SHORT_CYC[16:0];
	assign lag_done = (lag_q >= lag_len - 17'h00001);
	assign auto_hit = (ms_q == MS_STOP) && ctrl_q[`SMC_CTRL_AUTO] &&
		!auto_pwm_q && load_s;

	always @* begin
		ms_d = ms_q;
		case (ms_q)
		MS_OFF: begin
			if (supply_run) begin
				// A stop reached straight from off still waits out the lag.
				ms_d = in_stop ? MS_LAG : MS_RUN;
			end
		end
		MS_RUN: begin
			if (in_stop) begin
				ms_d = MS_LAG;
			end
		end
		MS_LAG: begin
			if (!in_stop) begin
				ms_d = MS_RUN;
			end else if (lag_done) begin
				ms_d = MS_STOP;
			end
		end
		// A fresh stop command after an automatic change goes back to PFM.
		MS_STOP: begin
			if (!in_stop) begin
				ms_d = MS_RUN;
			end else if (STOP_CMD && auto_pwm_q) begin
				ms_d = MS_LAG;
			end
		end
		default: begin
			ms_d = MS_OFF;
		end
		endcase
		if (!supply_run) begin
			ms_d = MS_OFF;
		end
	end

	always @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			ms_q        <= MS_OFF;
			lag_q       <= 17'h00000;
			auto_pwm_q  <= 1'b0;
			mode_prev_q <= 3'h0;
			power_up_q  <= 1'b1;
		end else begin
			ms_q        <= ms_d;
			mode_prev_q <= CHIP_MODE;
			if (supply_run) begin
				power_up_q <= 1'b0;
			end
			if (ms_d == MS_LAG && ms_q != MS_LAG) begin
				lag_q <= 17'h00000;
			end else if (ms_q == MS_LAG && !lag_done) begin
				lag_q <= lag_q + 17'h00001;
			end
			// Held until stop mode is left or a fresh stop command re-arms the low-power mode.
			if (ms_d != MS_STOP) begin
				auto_pwm_q <= 1'b0;
			end else if (auto_hit) begin
				auto_pwm_q <= 1'b1;
			end
		end
	end

	// Stop-mode modulation choice; automatic has priority over the pin.
	always @* begin
		pwm_d = 1'b0;
		if (ms_d == MS_RUN) begin
			pwm_d = 1'b1;
		end else if (ms_d == MS_STOP) begin
			if (ctrl_q[`SMC_CTRL_AUTO]) begin
				pwm_d = auto_pwm_q || auto_hit;
			end else if (ctrl_q[`SMC_CTRL_WAKE_SEL]) begin
				pwm_d = wake_s;
			end
		end else if (ms_d == MS_LAG) begin
			// The pin needs no lag: the far side drives a defined level.
			if (!ctrl_q[`SMC_CTRL_AUTO] &&
				ctrl_q[`SMC_CTRL_WAKE_SEL]) begin
				pwm_d = wake_s;
			end
		end
	end

	// Step-up hysteresis; off whenever disabled or supply is down.
	always @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			up_on_q <= 1'b0;
		end else if (!supply_run || !ctrl_q[`SMC_CTRL_UP_EN]) begin
			up_on_q <= 1'b0;
		end else if (below_s) begin
			up_on_q <= 1'b1;
		end else if (above_s) begin
			up_on_q <= 1'b0;
		end
	end

	// Sticky flags: a set in the same cycle as a clear wins.
	always @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			up_flag_q  <= 1'b0;
			mod_flag_q <= 1'b0;
			cmd_err_q  <= 1'b0;
		end else begin
			if (up_on_q) begin
				up_flag_q <= 1'b1;
			end else if (wr_status && WDATA[`SMC_ST_UP_FLAG]) begin
				up_flag_q <= 1'b0;
			end
			if (auto_hit) begin
				mod_flag_q <= 1'b1;
			end else if (wr_status && WDATA[`SMC_ST_MOD_FLAG]) begin
				mod_flag_q <= 1'b0;
			end
			if (wr_ctrl && vsel_clash) begin
				cmd_err_q <= 1'b1;
			end else if (wr_status && WDATA[`SMC_ST_CMD_ERR]) begin
				cmd_err_q <= 1'b0;
			end
		end
	end

	assign status_word = {1'b0, ss_closed, ss_busy, STEP_DOWN_PWM,
		up_on_q, cmd_err_q, mod_flag_q, up_flag_q};
	// Faults are only reported here and steer nothing.
	assign fault_word = {6'h00, fshort_s, fopen_s};

	always @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			RDATA <= 8'h00;
		end else if (RD) begin
			case (ADDR)
			`SMC_ADDR_CTRL: begin
				RDATA <= ctrl_q;
			end
			`SMC_ADDR_STATUS: begin
				RDATA <= status_word;
			end
			`SMC_ADDR_FAULT: begin
				RDATA <= fault_word;
			end
			default: begin
				RDATA <= 8'h00;
			end
			endcase
		end else begin
			RDATA <= 8'h00;
		end
	end

	always @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			STEP_DOWN_EN           <= 1'b0;
			STEP_DOWN_PWM          <= 1'b0;
			STEP_DOWN_CLOSED_LOOP  <= 1'b0;
			STEP_DOWN_FULL_DUTY_OK <= 1'b0;
			STEP_DOWN_DUTY         <= 8'h00;
			STEP_UP_ON             <= 1'b0;
			STEP_UP_VSEL           <= 2'h0;
			FAIL_OUTPUT            <= 1'b0;
			MOD_CHANGE_EVENT       <= 1'b0;
		end else begin
			STEP_DOWN_EN  <= supply_run;
			// Soft-start runs at fixed frequency, so PWM is forced there.
			STEP_DOWN_PWM <= supply_run && (pwm_d || ss_busy);
			STEP_DOWN_CLOSED_LOOP <= ss_closed && !ss_busy;
			STEP_DOWN_FULL_DUTY_OK <= ss_closed && pwm_d;
			STEP_DOWN_DUTY <= ss_duty;
			// Gated by the live mode so the stage stops with the supply.
			STEP_UP_ON     <= up_on_q && supply_run;
			STEP_UP_VSEL   <= vsel_cur;
			FAIL_OUTPUT    <= ov_s && ctrl_q[`SMC_CTRL_OV_FAIL];
			MOD_CHANGE_EVENT <= auto_hit;
		end
	end
endmodule // smc_top

// *** tb/smc_sva.sv ***
`timescale 1ns/1ps
module smc_sva (
	input wire       REF_CLK,
	input wire       RESETN,
	input wire [2:0] CHIP_MODE,
	input wire       WR,
	input wire [3:0] ADDR,
	input wire       WAKE_INPUT,
	input wire       IO_SUPPLY_SENSE_OV,
	input wire       OUT_TARGET_HIT,
	input wire       STEP_DOWN_EN,
	input wire       STEP_DOWN_PWM,
	input wire       STEP_DOWN_CLOSED_LOOP,
	input wire       STEP_DOWN_FULL_DUTY_OK,
	input wire [7:0] STEP_DOWN_DUTY,
	input wire       STEP_UP_ON,
	input wire [1:0] STEP_UP_VSEL,
	input wire       FAIL_OUTPUT,
	input wire       MOD_CHANGE_EVENT
);
	// Seven quiet cycles mean the synchronised wake level is surely low.
	reg [2:0] wake_lo_q;
	always @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN)
			wake_lo_q <= 3'h0;
		else if (WAKE_INPUT)
			wake_lo_q <= 3'h0;
		else if (wake_lo_q != 3'h7)
			wake_lo_q <= wake_lo_q + 3'h1;
	end
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESETN);
	a_off_modes: assert property (
		(CHIP_MODE == 3'h4 || CHIP_MODE == 3'h5) |=> !STEP_DOWN_EN && !STEP_UP_ON)
		else $error("Supply running in an off mode.");
	a_run_modes: assert property (
		($past(RESETN) && CHIP_MODE >= 3'h1 && CHIP_MODE <= 3'h3)
		|=> STEP_DOWN_EN)
		else $error("Supply off in a run mode.");
	a_stop_pfm: assert property (
		(CHIP_MODE == 3'h2 && $past(CHIP_MODE) == 3'h1 && STEP_DOWN_CLOSED_LOOP
		&& wake_lo_q == 3'h7) |=> !STEP_DOWN_PWM)
		else $error("Stop entry kept fixed frequency.");
	a_full_duty: assert property (
		STEP_DOWN_FULL_DUTY_OK |-> STEP_DOWN_CLOSED_LOOP && STEP_DOWN_PWM)
		else $error("Full duty outside closed loop.");
	a_event_pulse: assert property (
		MOD_CHANGE_EVENT |-> (STEP_DOWN_PWM && !$past(STEP_DOWN_PWM))
		##1 !MOD_CHANGE_EVENT)
		else $error("Modulation event malformed.");
	a_vsel_write: assert property (
		$changed(STEP_UP_VSEL) |-> $past(WR && ADDR == 4'h0, 2))
		else $error("Voltage select changed without a write.");
	a_fail_cause: assert property (
		$rose(FAIL_OUTPUT) |-> $past(IO_SUPPLY_SENSE_OV, 2))
		else $error("Fail output without overvoltage.");
	a_duty_start: assert property (
		($changed(STEP_DOWN_DUTY) && $past(STEP_DOWN_DUTY) == 8'h00)
		|-> STEP_DOWN_DUTY == 8'h08)
		else $error("Soft-start did not begin at minimum duty.");
	a_duty_step: assert property (
		($changed(STEP_DOWN_DUTY) && STEP_DOWN_DUTY != 8'h00
		&& $past(STEP_DOWN_DUTY) != 8'h00)
		|-> STEP_DOWN_DUTY == $past(STEP_DOWN_DUTY) + 8'h04)
		else $error("Soft-start step is not fixed.");
	a_closed_cause: assert property (
		$rose(STEP_DOWN_CLOSED_LOOP) |-> $past(OUT_TARGET_HIT, 2))
		else $error("Loop closed before target voltage.");
	c_event: cover property (MOD_CHANGE_EVENT);
	c_closed: cover property ($rose(STEP_DOWN_CLOSED_LOOP));
	c_up_on: cover property ($rose(STEP_UP_ON));
	c_fail: cover property ($rose(FAIL_OUTPUT));
endmodule // smc_sva

bind smc_top smc_sva i_sva (.REF_CLK, .RESETN, .CHIP_MODE, .WR, .ADDR,
	.WAKE_INPUT, .IO_SUPPLY_SENSE_OV, .OUT_TARGET_HIT, .STEP_DOWN_EN,
	.STEP_DOWN_PWM, .STEP_DOWN_CLOSED_LOOP, .STEP_DOWN_FULL_DUTY_OK,
	.STEP_DOWN_DUTY, .STEP_UP_ON, .STEP_UP_VSEL, .FAIL_OUTPUT,
	.MOD_CHANGE_EVENT);

// *** tb/smc_plant.sv ***
`timescale 1ns/1ps
module smc_plant #(
	parameter [7:0] HIT_DUTY = 8'h10
) (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       en,
	input  wire [7:0] duty,
	output reg        target_hit_q
);
	// A stage that stops switching lets the output sag, so every restart
	// has to ramp again before the target is seen.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			target_hit_q <= 1'b0;
		else if (!en)
			target_hit_q <= 1'b0;
		else if (duty >= HIT_DUTY)
			target_hit_q <= 1'b1;
	end
endmodule // smc_plant

// *** tb/smc_tb.sv ***
`timescale 1ns/1ps
module testbench;
	reg        ref_clk, resetn, stop_cmd, wr, rd, wake, load_hi;
	reg        sup_low, sup_high, io_ov, flt_open, flt_short;
	reg  [2:0] chip_mode;
	reg  [3:0] addr;
	reg  [7:0] wdata;
	wire [7:0] rdata, sd_duty;
	wire [1:0] up_vsel;
	wire       tgt_hit, sd_en, sd_pwm, sd_closed, sd_full, up_on;
	wire       fail_out, mod_evt;
	integer    miscompares, tests_run, n;
	smc_top #(.TLAG_SHORT_CYC(20), .TLAG_LONG_CYC(40), .SW_PERIOD_CYC(4),
		.SS_HOLD_PER(4)) i_dut (
		.REF_CLK(ref_clk), .RESETN(resetn), .CHIP_MODE(chip_mode),
		.STOP_CMD(stop_cmd), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .SUPPLY_BELOW_TH(sup_low),
		.SUPPLY_ABOVE_HYST(sup_high), .LOAD_OVER_TH(load_hi),
		.WAKE_INPUT(wake), .IO_SUPPLY_SENSE_OV(io_ov),
		.OUT_TARGET_HIT(tgt_hit), .FAULT_OPEN(flt_open),
		.FAULT_SHORT(flt_short), .STEP_DOWN_EN(sd_en),
		.STEP_DOWN_PWM(sd_pwm), .STEP_DOWN_CLOSED_LOOP(sd_closed),
		.STEP_DOWN_FULL_DUTY_OK(sd_full), .STEP_DOWN_DUTY(sd_duty),
		.STEP_UP_ON(up_on), .STEP_UP_VSEL(up_vsel),
		.FAIL_OUTPUT(fail_out), .MOD_CHANGE_EVENT(mod_evt));
	smc_plant i_plant (.clk(ref_clk), .rst_n(resetn), .en(sd_en),
		.duty(sd_duty), .target_hit_q(tgt_hit));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task chk(input [7:0] seen, input [7:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp) begin
			miscompares = miscompares + 1;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task close_out;
		if (miscompares == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task tick(input integer c);
		repeat (c) @(posedge ref_clk);
		#1;
	endtask
	task reg_wr(input [3:0] a, input [7:0] d);
		@(posedge ref_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	task reg_rd(input [3:0] a, input [7:0] m, input [7:0] exp);
		@(posedge ref_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		chk(rdata & m, exp);
	endtask
	task wait_closed;
		n = 0;
		while (sd_closed !== 1'b1 && n < 400) begin
			tick(1);
			n = n + 1;
		end
		if (n == 400) begin
			miscompares = miscompares + 1;
			$display("[FAIL] %0t soft-start never closed the loop", $time);
			close_out;
		end
	endtask
	// Stop entry is always made with the wake pin long quiet, so only the
	// configured policy can hold fixed frequency afterwards.
	task stop_run(input [7:0] cfg, input exp_wake, input exp_auto);
		chip_mode <= 3'h1;
		reg_wr(4'h0, cfg);
		tick(8);
		chip_mode <= 3'h2;
		tick(2);
		chk(sd_pwm, 1'b0);
		wake <= 1'b1;
		tick(6);
		chk(sd_pwm, exp_wake);
		wake <= 1'b0;
		tick(6);
		chk(sd_pwm, 1'b0);
		load_hi <= 1'b1;
		n = 0;
		while (mod_evt !== 1'b1 && n < 40) begin
			tick(1);
			n = n + 1;
		end
		chk(sd_pwm, exp_auto);
		chk(n < 40, exp_auto);
		chk(exp_auto && n > 20, exp_auto && cfg[5]);
		load_hi <= 1'b0;
	endtask
	initial begin
		miscompares = 0;
		tests_run = 0;
		{resetn, stop_cmd, wr, rd, wake, load_hi} = 6'h00;
		{sup_low, sup_high, io_ov, flt_open, flt_short} = 5'h00;
		chip_mode = 3'h1;
		addr = 4'h0;
		wdata = 8'h00;
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		reg_rd(4'h0, 8'hFF, 8'h00);
		reg_rd(4'hC, 8'hFF, 8'h00);
		chk(sd_duty, 8'h08);
		wait_closed;
		chk(sd_full, 1'b1);
		chk(sd_pwm, 1'b1);
		reg_rd(4'h4, 8'hFF, 8'h50);
		reg_wr(4'h0, 8'h05);
		sup_low <= 1'b1;
		tick(8);
		chk(up_vsel, 2'h2);
		chk(up_on, 1'b1);
		reg_wr(4'h0, 8'h03);
		tick(3);
		chk(up_vsel, 2'h2);
		reg_rd(4'h4, 8'hFF, 8'h5D);
		sup_low <= 1'b0;
		sup_high <= 1'b1;
		tick(8);
		chk(up_on, 1'b0);
		reg_rd(4'h4, 8'hFF, 8'h55);
		reg_wr(4'h4, 8'h05);
		reg_rd(4'h4, 8'hFF, 8'h50);
		reg_wr(4'h0, 8'h04);
		reg_wr(4'h0, 8'h02);
		tick(2);
		chk(up_vsel, 2'h1);
		{flt_open, flt_short} <= 2'h3;
		tick(8);
		reg_rd(4'h8, 8'hFF, 8'h03);
		reg_rd(4'h0, 8'hFF, 8'h02);
		chk({sd_en, sd_pwm, sd_closed}, 3'h7);
		{flt_open, flt_short} <= 2'h0;
		io_ov <= 1'b1;
		tick(8);
		chk(fail_out, 1'b0);
		reg_wr(4'h0, 8'h42);
		tick(3);
		chk(fail_out, 1'b1);
		io_ov <= 1'b0;
		stop_run(8'h02, 1'b0, 1'b0);
		stop_run(8'h12, 1'b1, 1'b0);
		stop_run(8'h1A, 1'b0, 1'b1);
		reg_rd(4'h4, 8'h02, 8'h02);
		@(posedge ref_clk);
		stop_cmd <= 1'b1;
		@(posedge ref_clk);
		stop_cmd <= 1'b0;
		tick(3);
		chk(sd_pwm, 1'b0);
		stop_run(8'h2A, 1'b0, 1'b1);
		chip_mode <= 3'h4;
		tick(2);
		chk({sd_en, up_on}, 2'h0);
		chip_mode <= 3'h3;
		tick(4);
		chk({sd_en, sd_closed}, 2'h2);
		chk(sd_duty, 8'h08);
		wait_closed;
		chip_mode <= 3'h5;
		tick(2);
		chk(sd_en, 1'b0);
		close_out;
	end
endmodule // testbench
